// >>> dual_data_address_generator.sv
/*
  Two concurrent address generators plus the program word extension
  register. Assumes core-clock inputs; memories take addresses one
  cycle after a use request.
*/

// Behaviour
// RULE1: each generator holds four pointer, modify, length sets
// RULE2: output pointer, then add selected modifier
// RULE3: nonzero length wraps pointer inside circular buffer
// RULE4: first generator data only, optional bit reversal
// RULE5: second generator program or data, no reversal
// RULE6: both generators work in the same cycle
// RULE7: serial port borrows circular pointers for transfers
// RULE8: program memory write takes low byte from extension
// RULE9: program memory data read puts low byte in extension
// RULE10: zero length means plain linear post-modify
module dual_data_address_generator
  import dag_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  input  wire logic              reg_load_i,
  input  wire logic              reg_gen2_i,
  input  wire reg_kind_e         reg_kind_i,
  input  wire logic [SEL_W-1:0]  reg_idx_i,
  input  wire logic [ADDR_W-1:0] reg_data_i,
  input  wire logic              g1_use_i,
  input  wire logic [SEL_W-1:0]  g1_i_sel_i,
  input  wire logic [SEL_W-1:0]  g1_m_sel_i,
  input  wire logic              bitrev_en_i,
  input  wire logic              g2_use_i,
  input  wire logic [SEL_W-1:0]  g2_i_sel_i,
  input  wire logic [SEL_W-1:0]  g2_m_sel_i,
  input  wire logic              g2_space_pm_i,
  input  wire logic              sport_req_i,
  input  wire logic [SEL_W-1:0]  sport_i_sel_i,
  input  wire logic [SEL_W-1:0]  sport_m_sel_i,
  output      logic              sport_grant_o,
  output      logic              core_stall_o,
  output      logic [ADDR_W-1:0] dm_addr_o,
  output      logic              dm_addr_valid_o,
  output      logic [ADDR_W-1:0] pm_addr_o,
  output      logic              pm_addr_valid_o,
  input  wire logic              px_load_i,
  input  wire logic [EXT_W-1:0]  px_data_i,
  output      logic [EXT_W-1:0]  px_o,
  input  wire logic              pm_wr_i,
  input  wire logic [REG_W-1:0]  pm_reg_wdata_i,
  output      logic [PMW_W-1:0]  pm_wdata_o,
  input  wire logic              pm_data_rd_i,
  input  wire logic [PMW_W-1:0]  pm_rdata_i,
  output      logic [REG_W-1:0]  pm_reg_rdata_o
);
  gen_if g1 ();
  gen_if g2 ();

  logic             g1_valid_reg;
  logic             g1_valid_next;
  logic             g2_valid_reg;
  logic             g2_valid_next;
  logic             g2_pm_reg;
  logic             g2_pm_next;
  logic [EXT_W-1:0] px_reg;
  logic [EXT_W-1:0] px_next;
  logic [PMW_W-1:0] pm_wdata_reg;
  logic [PMW_W-1:0] pm_wdata_next;
  logic [REG_W-1:0] pm_rdata_reg;
  logic [REG_W-1:0] pm_rdata_next;

  // ----------------------------------------------------------------------
  // Generators
  // ----------------------------------------------------------------------
  // The serial port steals the first generator for one cycle per word;
  // the core instruction stalls rather than lose its access.
  assign sport_grant_o = sport_req_i; // see RULE7
  assign core_stall_o  = sport_req_i && g1_use_i;

  assign g1.load_en   = reg_load_i && !reg_gen2_i;
  assign g1.load_kind = reg_kind_i;
  assign g1.load_idx  = reg_idx_i;
  assign g1.load_data = reg_data_i;
  assign g1.use_en    = g1_use_i || sport_req_i;
  assign g1.use_i     = sport_req_i ? sport_i_sel_i : g1_i_sel_i; // see RULE7
  assign g1.use_m     = sport_req_i ? sport_m_sel_i : g1_m_sel_i;
  assign g1.bitrev    = bitrev_en_i && !sport_req_i;

  assign g2.load_en   = reg_load_i && reg_gen2_i;
  assign g2.load_kind = reg_kind_i;
  assign g2.load_idx  = reg_idx_i;
  assign g2.load_data = reg_data_i;
  assign g2.use_en    = g2_use_i;
  assign g2.use_i     = g2_i_sel_i;
  assign g2.use_m     = g2_m_sel_i;
  assign g2.bitrev    = 1'h0; // see RULE5

  // Four register sets in each generator see RULE1
  addr_gen #(.HAS_BITREV(1'b1)) u_data_only_address_generator (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .g         (g1.gen)
  );

  addr_gen #(.HAS_BITREV(1'b0)) u_dual_space_address_generator (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .g         (g2.gen)
  );

  // ----------------------------------------------------------------------
  // Address routing and extension register
  // ----------------------------------------------------------------------
  always_comb begin
    g1_valid_next = g1.use_en;
    g2_valid_next = g2.use_en;
    g2_pm_next    = g2_space_pm_i;
    px_next       = px_reg;
    pm_wdata_next = pm_wdata_reg;
    pm_rdata_next = pm_rdata_reg;
    if (px_load_i) begin
      px_next = px_data_i;
    end
    if (pm_wr_i) begin
      pm_wdata_next = {pm_reg_wdata_i, px_reg}; // see RULE8
    end
    // Data read wins over a same-cycle direct load of the extension
    if (pm_data_rd_i) begin
      pm_rdata_next = pm_rdata_i[PMW_W-1:EXT_W];
      px_next       = pm_rdata_i[EXT_W-1:0]; // see RULE9
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      g1_valid_reg <= 1'h0;
      g2_valid_reg <= 1'h0;
      g2_pm_reg    <= 1'h0;
      px_reg       <= EXT_ZERO;
      pm_wdata_reg <= PMW_ZERO;
      pm_rdata_reg <= REG_ZERO;
    end else begin
      g1_valid_reg <= g1_valid_next;
      g2_valid_reg <= g2_valid_next;
      g2_pm_reg    <= g2_pm_next;
      px_reg       <= px_next;
      pm_wdata_reg <= pm_wdata_next;
      pm_rdata_reg <= pm_rdata_next;
    end
  end

  // First generator owns the data bus; second reaches it only when free
  assign dm_addr_o       = g1_valid_reg ? g1.addr : g2.addr; // see RULE4
  assign dm_addr_valid_o = g1_valid_reg || (g2_valid_reg && !g2_pm_reg);
  assign pm_addr_o       = g2.addr; // see RULE6
  assign pm_addr_valid_o = g2_valid_reg && g2_pm_reg;
  assign px_o            = px_reg;
  assign pm_wdata_o      = pm_wdata_reg;
  assign pm_reg_rdata_o  = pm_rdata_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_dual_operand: assert property ( // see RULE6
    (g1_use_i && !sport_req_i && g2_use_i && g2_space_pm_i) |=>
      (dm_addr_valid_o && pm_addr_valid_o))
    else $error("both operand addresses not issued together");

  a_g1_data_only: assert property ( // see RULE4
    (g1.use_en && !g2_use_i) |=> (dm_addr_valid_o && !pm_addr_valid_o))
    else $error("first generator drove program memory");

  a_ext_on_write: assert property ( // see RULE8
    pm_wr_i |=> pm_wdata_o == {$past(pm_reg_wdata_i), $past(px_reg)})
    else $error("program write low byte not from extension");

  a_ext_on_read: assert property ( // see RULE9
    pm_data_rd_i |=> (px_o == $past(pm_rdata_i[EXT_W-1:0]) &&
                      pm_reg_rdata_o == $past(pm_rdata_i[PMW_W-1:EXT_W])))
    else $error("program data read did not fill extension");

  a_sport_access: assert property ( // see RULE7
    sport_req_i |-> (sport_grant_o && g1.use_i == sport_i_sel_i)
      ##1 dm_addr_valid_o)
    else $error("serial port transfer not served");

  // ----------------------------------------------------------------------
  // Hold and routing checks
  // ----------------------------------------------------------------------
  // Extension and data words must not drift between strobes, or a
  // later program access would pick up a stale low byte.
  a_px_holds: assert property ( // see RULE8
    (!px_load_i && !pm_data_rd_i) |=> px_o == $past(px_o))
    else $error("extension register changed without a load");

  a_px_direct_load: assert property ( // see RULE8
    (px_load_i && !pm_data_rd_i) |=> px_o == $past(px_data_i))
    else $error("direct load of extension register lost");

  a_wdata_holds: assert property ( // see RULE8
    !pm_wr_i |=> $stable(pm_wdata_o))
    else $error("program write word changed without a write");

  a_rdata_holds: assert property ( // see RULE9
    !pm_data_rd_i |=> $stable(pm_reg_rdata_o))
    else $error("program read word changed without a read");

  a_second_to_dm: assert property ( // see RULE5
    (g2_use_i && !g2_space_pm_i && !g1.use_en) |=>
      (dm_addr_valid_o && !pm_addr_valid_o && dm_addr_o == pm_addr_o))
    else $error("second generator data address not on data bus");

  a_second_to_pm: assert property ( // see RULE5
    (g2_use_i && g2_space_pm_i) |=> pm_addr_valid_o)
    else $error("second generator program address not issued");

  // First generator must win the data bus over the second
  a_dm_from_first: assert property ( // see RULE4
    g1.use_en |=> (dm_addr_valid_o && dm_addr_o == g1.addr))
    else $error("data bus not driven by first generator");

  a_idle_no_valid: assert property ( // see RULE2
    (!g1.use_en && !g2_use_i) |=> (!dm_addr_valid_o && !pm_addr_valid_o))
    else $error("address valid without a use request");
endmodule : dual_data_address_generator

// >>> dag_pkg.sv
/*
  Shared constants, types and helper functions for the dual address
  generator unit. Assumes a single core clock domain.
*/
package dag_pkg;
  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W  = 14;
  localparam int unsigned PTR_N   = 4;
  localparam int unsigned SEL_W   = 2;
  localparam int unsigned REG_W   = 16;
  localparam int unsigned PMW_W   = 24;
  localparam int unsigned EXT_W   = 8;

  localparam logic [ADDR_W-1:0] ADDR_ZERO = 14'h0000;
  localparam logic [EXT_W-1:0]  EXT_ZERO  = 8'h00;
  localparam logic [REG_W-1:0]  REG_ZERO  = 16'h0000;
  localparam logic [PMW_W-1:0]  PMW_ZERO  = 24'h00_0000;

  typedef enum logic [1:0] {
    KIND_PTR,
    KIND_MOD,
    KIND_LEN
  } reg_kind_e;

  // ----------------------------------------------------------------------
  // Post-modify with optional circular wrap; zero length is linear
  // ----------------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] post_modify(
    input logic [ADDR_W-1:0] ptr,
    input logic [ADDR_W-1:0] modv,
    input logic [ADDR_W-1:0] len,
    input logic [ADDR_W-1:0] base
  );
    logic [ADDR_W:0]   lin;
    logic [ADDR_W:0]   lim;
    logic [ADDR_W-1:0] mag;
    logic [ADDR_W-1:0] res;
    lin = {1'h0, ptr} + {1'h0, modv};
    lim = {1'h0, base} + {1'h0, len};
    mag = ADDR_ZERO - modv;
    res = lin[ADDR_W-1:0];
    if (len != ADDR_ZERO) begin
      if (!modv[ADDR_W-1]) begin
        if (lin >= lim) begin
          res = lin[ADDR_W-1:0] - len;
        end
      end else if ({1'h0, ptr} < ({1'h0, base} + {1'h0, mag})) begin
        res = lin[ADDR_W-1:0] + len;
      end
    end
    return res;
  endfunction : post_modify

  function automatic logic [ADDR_W-1:0] bit_reverse(
    input logic [ADDR_W-1:0] a
  );
    logic [ADDR_W-1:0] r;
    r = ADDR_ZERO;
    for (int k = 0; k < ADDR_W; k++) begin
      r[k] = a[ADDR_W-1-k];
    end
    return r;
  endfunction : bit_reverse
endpackage : dag_pkg

// >>> gen_if.sv
/*
  Control and address signals between the unit top and one generator.
  Assumes both ends share the core clock.
*/
interface gen_if;
  import dag_pkg::*;
  logic              load_en;
  reg_kind_e         load_kind;
  logic [SEL_W-1:0]  load_idx;
  logic [ADDR_W-1:0] load_data;
  logic              use_en;
  logic [SEL_W-1:0]  use_i;
  logic [SEL_W-1:0]  use_m;
  logic              bitrev;
  logic [ADDR_W-1:0] addr;

  modport gen  (input load_en, load_kind, load_idx, load_data, use_en,
                use_i, use_m, bitrev, output addr);
  modport ctrl (output load_en, load_kind, load_idx, load_data, use_en,
                use_i, use_m, bitrev, input addr);
endinterface : gen_if

// >>> addr_gen.sv
/*
  One address generator: four pointers, four modifiers, four lengths.
  Assumes the top sequences loads and uses on the core clock.
*/
module addr_gen
  import dag_pkg::*;
#(
  parameter bit HAS_BITREV = 1'b0
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  gen_if.gen        g
);
  logic [ADDR_W-1:0] ptr_reg  [PTR_N];
  logic [ADDR_W-1:0] ptr_next [PTR_N];
  logic [ADDR_W-1:0] mod_reg  [PTR_N];
  logic [ADDR_W-1:0] mod_next [PTR_N];
  logic [ADDR_W-1:0] len_reg  [PTR_N];
  logic [ADDR_W-1:0] len_next [PTR_N];
  logic [ADDR_W-1:0] base_reg [PTR_N];
  logic [ADDR_W-1:0] base_next[PTR_N];
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_next;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    ptr_next  = ptr_reg;
    mod_next  = mod_reg;
    len_next  = len_reg;
    base_next = base_reg;
    addr_next = addr_reg;
    if (g.use_en) begin
      // Current value goes out, then post-modify see RULE2
      addr_next = (HAS_BITREV && g.bitrev) ?
                  bit_reverse(ptr_reg[g.use_i]) : ptr_reg[g.use_i]; // see RULE4
      ptr_next[g.use_i] = post_modify(ptr_reg[g.use_i],
                                      mod_reg[g.use_m],
                                      len_reg[g.use_i],
                                      base_reg[g.use_i]); // see RULE3 RULE10
    end
    // A load overrides a same-cycle post-modify of that pointer
    if (g.load_en) begin
      unique case (g.load_kind)
        KIND_PTR: begin
          ptr_next[g.load_idx]  = g.load_data;
          base_next[g.load_idx] = g.load_data;
        end
        KIND_MOD: mod_next[g.load_idx] = g.load_data;
        KIND_LEN: len_next[g.load_idx] = g.load_data;
        default:  ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      for (int k = 0; k < PTR_N; k++) begin
        ptr_reg[k]  <= ADDR_ZERO;
        mod_reg[k]  <= ADDR_ZERO;
        len_reg[k]  <= ADDR_ZERO;
        base_reg[k] <= ADDR_ZERO;
      end
      addr_reg <= ADDR_ZERO;
    end else begin
      ptr_reg  <= ptr_next;
      mod_reg  <= mod_next;
      len_reg  <= len_next;
      base_reg <= base_next;
      addr_reg <= addr_next;
    end
  end

  assign g.addr = addr_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_addr_is_ptr: assert property ( // see RULE2
    (g.use_en && !(HAS_BITREV && g.bitrev)) |=>
      g.addr == $past(ptr_reg[g.use_i]))
    else $error("address is not the pointer value");

  a_linear_step: assert property ( // see RULE10
    (g.use_en && !g.load_en && len_reg[g.use_i] == ADDR_ZERO) |=>
      ptr_reg[$past(g.use_i)] ==
        $past(ptr_reg[g.use_i]) + $past(mod_reg[g.use_m]))
    else $error("zero length pointer did not step linearly");

  a_ptr_in_buffer: assert property ( // see RULE3
    (g.use_en && !g.load_en && len_reg[g.use_i] != ADDR_ZERO &&
     ptr_reg[g.use_i] >= base_reg[g.use_i] &&
     {1'h0, ptr_reg[g.use_i]} <
       {1'h0, base_reg[g.use_i]} + {1'h0, len_reg[g.use_i]} &&
     mod_reg[g.use_m][ADDR_W-2:0] < len_reg[g.use_i][ADDR_W-2:0]) |=>
      (ptr_reg[$past(g.use_i)] >= base_reg[$past(g.use_i)] &&
       {1'h0, ptr_reg[$past(g.use_i)]} <
         {1'h0, base_reg[$past(g.use_i)]} +
         {1'h0, len_reg[$past(g.use_i)]}))
    else $error("circular pointer left its buffer");

  a_no_bitrev: assert property ( // see RULE5
    (!HAS_BITREV && g.use_en) |=> g.addr == $past(ptr_reg[g.use_i]))
    else $error("bit reversal on a generator without it");
endmodule : addr_gen

// >>> core_memory_model.sv
/*
  Behavioural program memory standing behind the address unit.
  Assumes the bench's program write strobe and a single core clock.
*/
module core_memory_model
  import dag_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic [ADDR_W-1:0] pm_addr_i,
  input  wire logic              pm_addr_valid_i,
  input  wire logic              pm_wr_i,
  input  wire logic [PMW_W-1:0]  pm_wdata_i,
  output      logic [PMW_W-1:0]  pm_rdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [PMW_W-1:0]  mem [0:63];
  logic [ADDR_W-1:0] addr_q;
  logic              wr_q;

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  // Unwritten words hold a changing pattern, not zeros
  initial begin
    addr_q = ADDR_ZERO;
    wr_q = 1'b0;
    for (int k = 0; k < 64; k++) begin
      mem[k] = 24'hA5_5A00 ^ PMW_W'(k);
    end
  end

  // Write word arrives one cycle after the strobe
  always @(posedge clk_sys_i) begin
    if (pm_addr_valid_i) begin
      addr_q <= pm_addr_i;
    end
    wr_q <= pm_wr_i;
    if (wr_q) begin
      mem[addr_q[5:0]] <= pm_wdata_i;
    end
  end

  assign pm_rdata_o = mem[addr_q[5:0]];
endmodule : core_memory_model

// >>> tb.sv
/*
  Self-checking bench for the dual address generator unit.
  Assumes inputs change on falling edges and outputs settle by then.
*/
module tb;
  import dag_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic reg_load_i = 1'b0, reg_gen2_i = 1'b0;
  reg_kind_e reg_kind_i = KIND_PTR;
  logic [SEL_W-1:0] reg_idx_i = 2'h0;
  logic [ADDR_W-1:0] reg_data_i = ADDR_ZERO;
  logic g1_use_i = 1'b0, bitrev_en_i = 1'b0, g2_use_i = 1'b0;
  logic [SEL_W-1:0] g1_i_sel_i = 2'h0, g1_m_sel_i = 2'h0;
  logic [SEL_W-1:0] g2_i_sel_i = 2'h0, g2_m_sel_i = 2'h0;
  logic g2_space_pm_i = 1'b0, sport_req_i = 1'b0;
  logic [SEL_W-1:0] sport_i_sel_i = 2'h3, sport_m_sel_i = 2'h3;
  logic sport_grant_o, core_stall_o, dm_addr_valid_o, pm_addr_valid_o;
  logic [ADDR_W-1:0] dm_addr_o, pm_addr_o;
  logic px_load_i = 1'b0, pm_wr_i = 1'b0, pm_data_rd_i = 1'b0;
  logic [EXT_W-1:0] px_data_i = EXT_ZERO;
  logic [EXT_W-1:0] px_o;
  logic [REG_W-1:0] pm_reg_wdata_i = REG_ZERO;
  logic [REG_W-1:0] pm_reg_rdata_o;
  logic [PMW_W-1:0] pm_wdata_o, pm_rdata_i;
  int bad_count = 0, n_checks = 0, cycles = 0;
  logic [ADDR_W-1:0] circ [0:7] = '{14'h0020, 14'h0023, 14'h0021,
    14'h0024, 14'h0022, 14'h0020, 14'h0023, 14'h0021};

  always #5 clk_sys_i = ~clk_sys_i;

  dual_data_address_generator dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .reg_load_i(reg_load_i), .reg_gen2_i(reg_gen2_i),
    .reg_kind_i(reg_kind_i), .reg_idx_i(reg_idx_i),
    .reg_data_i(reg_data_i), .g1_use_i(g1_use_i),
    .g1_i_sel_i(g1_i_sel_i), .g1_m_sel_i(g1_m_sel_i),
    .bitrev_en_i(bitrev_en_i), .g2_use_i(g2_use_i),
    .g2_i_sel_i(g2_i_sel_i), .g2_m_sel_i(g2_m_sel_i),
    .g2_space_pm_i(g2_space_pm_i), .sport_req_i(sport_req_i),
    .sport_i_sel_i(sport_i_sel_i), .sport_m_sel_i(sport_m_sel_i),
    .sport_grant_o(sport_grant_o), .core_stall_o(core_stall_o),
    .dm_addr_o(dm_addr_o), .dm_addr_valid_o(dm_addr_valid_o),
    .pm_addr_o(pm_addr_o), .pm_addr_valid_o(pm_addr_valid_o),
    .px_load_i(px_load_i), .px_data_i(px_data_i), .px_o(px_o),
    .pm_wr_i(pm_wr_i), .pm_reg_wdata_i(pm_reg_wdata_i),
    .pm_wdata_o(pm_wdata_o), .pm_data_rd_i(pm_data_rd_i),
    .pm_rdata_i(pm_rdata_i), .pm_reg_rdata_o(pm_reg_rdata_o));

  core_memory_model mem (.clk_sys_i(clk_sys_i), .pm_addr_i(pm_addr_o),
    .pm_addr_valid_i(pm_addr_valid_o), .pm_wr_i(pm_wr_i),
    .pm_wdata_i(pm_wdata_o), .pm_rdata_o(pm_rdata_i));

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic check(input string what, input logic [23:0] seen,
                       input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test

  // Strobes stay up so back-to-back calls never assign twice per step
  task automatic load(input logic g2, input reg_kind_e k,
                      input int idx, input logic [ADDR_W-1:0] d);
    reg_load_i = 1'b1;
    reg_gen2_i = g2;
    reg_kind_i = k;
    reg_idx_i = SEL_W'(idx);
    reg_data_i = d;
    @(negedge clk_sys_i);
  endtask : load

  task automatic use1(input int i, input int m);
    reg_load_i = 1'b0;
    g1_use_i = 1'b1;
    g1_i_sel_i = SEL_W'(i);
    g1_m_sel_i = SEL_W'(m);
    @(negedge clk_sys_i);
  endtask : use1

  task automatic idle();
    {reg_load_i, g1_use_i, g2_use_i, sport_req_i, bitrev_en_i} = 5'h00;
    {px_load_i, pm_wr_i, pm_data_rd_i} = 3'h0;
    @(negedge clk_sys_i);
  endtask : idle

  // Cycle ceiling well above the roughly sixty cycles the run needs
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      end_of_test();
    end
  end

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (5) @(negedge clk_sys_i);
    rst_i = 1'b0;
    check("px", px_o, 24'h00_0000);
    check("dm valid", dm_addr_valid_o, 24'h00_0000);
    check("pm word", pm_wdata_o, 24'h00_0000);
    for (int k = 0; k < 4; k++) begin
      load(1'b0, KIND_PTR, k, ADDR_W'(14'h0100 + k * 16));
      load(1'b0, KIND_MOD, k, ADDR_W'(k + 1));
      load(1'b0, KIND_LEN, k, ADDR_ZERO);
    end
    for (int k = 0; k < 4; k++) begin
      use1(k, k);
      check("dm first", dm_addr_o, 14'h0100 + k * 16);
      use1(k, k);
      check("dm next", dm_addr_o, 14'h0100 + k * 17 + 1);
      check("dm valid", dm_addr_valid_o, 24'h00_0001);
    end
    idle();
    check("dm valid idle", dm_addr_valid_o, 24'h00_0000);
    load(1'b0, KIND_PTR, 1, 14'h0020);
    load(1'b0, KIND_MOD, 1, 14'h0003);
    load(1'b0, KIND_LEN, 1, 14'h0005);
    load(1'b0, KIND_MOD, 2, 14'h3FFE);
    idle();
    for (int n = 0; n < 8; n++) begin
      use1(1, (n < 5) ? 1 : 2);
      check("dm circular", dm_addr_o, circ[n]);
    end
    bitrev_en_i = 1'b1;
    use1(0, 0);
    check("dm reversed", dm_addr_o, 24'h00_1020);
    idle();
    load(1'b1, KIND_PTR, 0, 14'h0040);
    load(1'b1, KIND_MOD, 0, 14'h0002);
    load(1'b1, KIND_LEN, 0, ADDR_ZERO);
    idle();
    {g2_use_i, g2_space_pm_i, g2_i_sel_i, g2_m_sel_i} = 6'h30;
    use1(0, 0);
    check("dm both", dm_addr_o, 24'h00_0103);
    check("pm both", pm_addr_o, 24'h00_0040);
    check("pm valid", pm_addr_valid_o, 24'h00_0001);
    g1_use_i = 1'b0;
    g2_space_pm_i = 1'b0;
    @(negedge clk_sys_i);
    check("dm from second", dm_addr_o, 24'h00_0042);
    check("pm idle", pm_addr_valid_o, 24'h00_0000);
    idle();
    load(1'b0, KIND_PTR, 3, 14'h0200);
    idle();
    sport_req_i = 1'b1;
    use1(0, 0);
    check("stall", {core_stall_o, sport_grant_o}, 24'h00_0003);
    check("dm serial", dm_addr_o, 24'h00_0200);
    idle();
    use1(0, 0);
    check("dm after steal", dm_addr_o, 24'h00_0104);
    idle();
    // Program word round trip through the memory model
    {px_load_i, px_data_i, g2_use_i, g2_space_pm_i} = 11'h56B;
    @(negedge clk_sys_i);
    {px_load_i, g2_use_i, pm_wr_i, pm_reg_wdata_i} = 19'h1_1234;
    @(negedge clk_sys_i);
    check("pm word", pm_wdata_o, 24'h12_345A);
    {pm_wr_i, px_load_i, px_data_i} = 10'h100;
    @(negedge clk_sys_i);
    check("px cleared", px_o, 24'h00_0000);
    // Direct load and data read together: the read must win
    {px_load_i, pm_data_rd_i} = 2'h3;
    @(negedge clk_sys_i);
    check("px read", px_o, 24'h00_005A);
    check("reg read", pm_reg_rdata_o, 24'h00_1234);
    idle();
    end_of_test();
  end
endmodule : tb
